// >>> ptc_pkg.sv
// constants shared by the time clock control block
package ptc_pkg;

  // ------------------------------------------------------------------
  // register map (byte addresses, 16-bit registers)
  // ------------------------------------------------------------------
  localparam logic [15:0] PTC_OFF_CTRL   = 16'h0500;
  localparam logic [15:0] PTC_OFF_PHASE  = 16'h0502;
  localparam logic [15:0] PTC_OFF_NS_HI  = 16'h0504;
  localparam logic [15:0] PTC_OFF_NS_LO  = 16'h0506;
  localparam logic [15:0] PTC_OFF_SEC_HI = 16'h0508;
  localparam logic [15:0] PTC_OFF_SEC_LO = 16'h050A;
  localparam logic [15:0] PTC_OFF_RATE_HI = 16'h050C;
  localparam logic [15:0] PTC_OFF_RATE_LO = 16'h050E;

  // ------------------------------------------------------------------
  // control register fields
  // ------------------------------------------------------------------
  localparam int PTC_CTL_NO_FOLLOW = 15;
  localparam int PTC_CTL_STEP      = 6;
  localparam int PTC_CTL_STEP_DIR  = 5;
  localparam int PTC_CTL_SNAP      = 4;
  localparam int PTC_CTL_LOAD      = 3;
  localparam int PTC_CTL_CONT_ADJ  = 2;
  localparam int PTC_CTL_ENABLE    = 1;
  localparam int PTC_CTL_RESET     = 0;

  // rate high word fields
  localparam int PTC_RATE_SIGN     = 15;
  localparam int PTC_RATE_HI_MSB   = 13;
  localparam int PTC_RATE_W        = 30;

  // phase field
  localparam int          PTC_PHASE_W   = 3;
  localparam logic [2:0]  PTC_PHASE_MAX = 3'h4;

  // reset values
  localparam logic [15:0] PTC_WORD_RST  = 16'h0000;
  localparam logic [31:0] PTC_LONG_RST  = 32'h0000_0000;
  localparam logic [2:0]  PTC_PHASE_RST = 3'h0;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int PTC_CLK_NS   = 20;   // system clock period
  localparam int PTC_TICK_NS  = 40;   // base tick of the time value
  localparam int PTC_TICK_CYC = (PTC_TICK_NS + PTC_CLK_NS - 1) / PTC_CLK_NS;
  localparam logic [6:0]  PTC_TICK_INC   = 7'(PTC_TICK_NS);
  localparam logic [32:0] PTC_NS_PER_SEC = 33'h0_3B9A_CA00;

endpackage : ptc_pkg

// >>> ptc_tick_gen.sv
// base tick divider: one pulse every DIV system clocks
`timescale 1ns/1ps
module ptc_tick_gen #(
  parameter int DIV = ptc_pkg::PTC_TICK_CYC
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // tick out
  output logic      tick_q
);
  import ptc_pkg::*;

  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic          tick_d;

  // free running divider; tick marks the last count
  always_comb begin
    tick_d = (cnt_q == LAST);
    cnt_d  = tick_d ? '0 : cnt_q + CW'(1);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

endmodule : ptc_tick_gen

// >>> ptc_time_clock_control.sv
// precision time clock with its software control registers
//
// Operation
// - bit 15 set: switch timers keep nominal rate; clear: follow corrections
// - step bit adds or subtracts held time once, then self-clears
// - step direction: one adds held time, zero subtracts it
// - snapshot bit copies running clock into time registers, self-clears
// - load bit overwrites clock with held time value, self-clears
// - continuous adjust applies fraction rate every base tick
// - clock advances only while the enable bit is one
// - reset bit clears the running clock, then self-clears
// - phase field gives 8 ns sub-phase, codes above 100 invalid
// - nanosecond upper word register, read/write, resets to zero
// - nanosecond lower word register completes the 32-bit value
// - two registers hold seconds high and low halves
// - rate sign bit: one adds fraction rate, zero subtracts
`timescale 1ns/1ps
module ptc_time_clock_control (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // register port
  input  wire logic [15:0] reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata_q,
  output logic             reg_rvalid_q,
  // running time
  output logic      [31:0] rtc_sec_q,
  output logic      [31:0] rtc_ns_q,
  output logic [ptc_pkg::PTC_PHASE_W-1:0] rtc_phase_q,
  // switch timer reference
  output logic             timer_tick_q,
  output logic      [6:0]  timer_ns_inc_q
);
  import ptc_pkg::*;

  // ------------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------------
  // 16-bit registers span two bytes, so the lowest bit is ignored
  function automatic logic hit(input logic [15:0] a, input logic [15:0] o);
    hit = (a[15:1] == o[15:1]);
  endfunction : hit

  logic wr_ctrl;
  logic wr_phase;
  logic wr_ns_hi;
  logic wr_ns_lo;
  logic wr_sec_hi;
  logic wr_sec_lo;
  logic wr_rate_hi;
  logic wr_rate_lo;

  always_comb begin
    wr_ctrl    = reg_wr && hit(reg_addr, PTC_OFF_CTRL);
    wr_phase   = reg_wr && hit(reg_addr, PTC_OFF_PHASE);
    wr_ns_hi   = reg_wr && hit(reg_addr, PTC_OFF_NS_HI);
    wr_ns_lo   = reg_wr && hit(reg_addr, PTC_OFF_NS_LO);
    wr_sec_hi  = reg_wr && hit(reg_addr, PTC_OFF_SEC_HI);
    wr_sec_lo  = reg_wr && hit(reg_addr, PTC_OFF_SEC_LO);
    wr_rate_hi = reg_wr && hit(reg_addr, PTC_OFF_RATE_HI);
    wr_rate_lo = reg_wr && hit(reg_addr, PTC_OFF_RATE_LO);
  end

  // ------------------------------------------------------------------
  // base tick
  // ------------------------------------------------------------------
  logic tick;

  ptc_tick_gen #(
    .DIV    (PTC_TICK_CYC)
  ) u_tick (
    .clk    (clk),
    .arst_n (arst_n),
    .tick_q (tick)
  );

  // ------------------------------------------------------------------
  // control and rate registers
  // ------------------------------------------------------------------
  logic        no_follow_q, no_follow_d;
  logic        step_dir_q,  step_dir_d;
  logic        cont_adj_q,  cont_adj_d;
  logic        enable_q,    enable_d;
  logic        rate_sign_select_q, rate_sign_select_d;
  logic [PTC_RATE_W-1:0] fraction_rate_value_q, fraction_rate_value_d;
  // one-cycle command pulses, they read back as one for a cycle only
  logic        cmd_step_q, cmd_step_d;
  logic        cmd_snap_q, cmd_snap_d;
  logic        cmd_load_q, cmd_load_d;
  logic        cmd_rst_q,  cmd_rst_d;

  always_comb begin
    no_follow_d           = no_follow_q;
    step_dir_d            = step_dir_q;
    cont_adj_d            = cont_adj_q;
    enable_d              = enable_q;
    rate_sign_select_d    = rate_sign_select_q;
    fraction_rate_value_d = fraction_rate_value_q;
    cmd_step_d            = wr_ctrl && reg_wdata[PTC_CTL_STEP];
    cmd_snap_d            = wr_ctrl && reg_wdata[PTC_CTL_SNAP];
    cmd_load_d            = wr_ctrl && reg_wdata[PTC_CTL_LOAD];
    cmd_rst_d             = wr_ctrl && reg_wdata[PTC_CTL_RESET];
    if (wr_ctrl) begin
      no_follow_d = reg_wdata[PTC_CTL_NO_FOLLOW];
      step_dir_d  = reg_wdata[PTC_CTL_STEP_DIR];
      cont_adj_d  = reg_wdata[PTC_CTL_CONT_ADJ];
      enable_d    = reg_wdata[PTC_CTL_ENABLE];
    end
    if (wr_rate_hi) begin
      rate_sign_select_d = reg_wdata[PTC_RATE_SIGN];
      fraction_rate_value_d[PTC_RATE_W-1:16] =
        reg_wdata[PTC_RATE_HI_MSB:0];
    end
    if (wr_rate_lo) begin
      fraction_rate_value_d[15:0] = reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      no_follow_q           <= 1'b0;
      step_dir_q            <= 1'b0;
      cont_adj_q            <= 1'b0;
      enable_q              <= 1'b0;
      rate_sign_select_q    <= 1'b0;
      fraction_rate_value_q <= '0;
      cmd_step_q            <= 1'b0;
      cmd_snap_q            <= 1'b0;
      cmd_load_q            <= 1'b0;
      cmd_rst_q             <= 1'b0;
    end else begin
      no_follow_q           <= no_follow_d;
      step_dir_q            <= step_dir_d;
      cont_adj_q            <= cont_adj_d;
      enable_q              <= enable_d;
      rate_sign_select_q    <= rate_sign_select_d;
      fraction_rate_value_q <= fraction_rate_value_d;
      cmd_step_q            <= cmd_step_d;
      cmd_snap_q            <= cmd_snap_d;
      cmd_load_q            <= cmd_load_d;
      cmd_rst_q             <= cmd_rst_d;
    end
  end

  // ------------------------------------------------------------------
  // held time registers (snapshot target, load and step source)
  // ------------------------------------------------------------------
  logic [PTC_PHASE_W-1:0] held_phase_q, held_phase_d;
  logic [31:0]            held_ns_q,    held_ns_d;
  logic [31:0]            held_sec_q,   held_sec_d;

  // a snapshot beats a software write landing in the same cycle
  always_comb begin
    held_phase_d = held_phase_q;
    held_ns_d    = held_ns_q;
    held_sec_d   = held_sec_q;
    if (wr_phase && reg_wdata[PTC_PHASE_W-1:0] <= PTC_PHASE_MAX) begin
      held_phase_d = reg_wdata[PTC_PHASE_W-1:0];
    end
    if (wr_ns_hi) held_ns_d[31:16] = reg_wdata;
    if (wr_ns_lo) held_ns_d[15:0]  = reg_wdata;
    if (wr_sec_hi) held_sec_d[31:16] = reg_wdata;
    if (wr_sec_lo) held_sec_d[15:0]  = reg_wdata;
    if (cmd_snap_q) begin
      held_phase_d = rtc_phase_q;
      held_ns_d    = rtc_ns_q;
      held_sec_d   = rtc_sec_q;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      held_phase_q <= PTC_PHASE_RST;
      held_ns_q    <= PTC_LONG_RST;
      held_sec_q   <= PTC_LONG_RST;
    end else begin
      held_phase_q <= held_phase_d;
      held_ns_q    <= held_ns_d;
      held_sec_q   <= held_sec_d;
    end
  end

  // ------------------------------------------------------------------
  // running clock
  // ------------------------------------------------------------------
  logic [PTC_RATE_W-1:0] frac_q, frac_d;
  logic [31:0]           sec_d;
  logic [31:0]           ns_d;
  logic [PTC_PHASE_W-1:0] phase_d;
  logic [PTC_RATE_W:0]   frac_sum;
  logic [6:0]            ns_inc;
  logic [32:0]           ns_sum;
  logic [32:0]           step_sum;
  logic                  step_carry;
  logic [6:0]            timer_inc_d;

  always_comb begin
    frac_d      = frac_q;
    sec_d       = rtc_sec_q;
    ns_d        = rtc_ns_q;
    phase_d     = rtc_phase_q;
    ns_inc      = PTC_TICK_INC;
    frac_sum    = {1'b0, frac_q};
    ns_sum      = '0;
    step_sum    = '0;
    step_carry  = 1'b0;
    // fraction accumulator: carry or borrow moves one nanosecond
    if (cont_adj_q) begin
      if (rate_sign_select_q) begin
        frac_sum = {1'b0, frac_q} + {1'b0, fraction_rate_value_q};
        ns_inc   = PTC_TICK_INC + 7'(frac_sum[PTC_RATE_W]);
      end else begin
        frac_sum = {1'b0, frac_q} - {1'b0, fraction_rate_value_q};
        ns_inc   = PTC_TICK_INC - 7'(frac_sum[PTC_RATE_W]);
      end
    end
    if (cmd_rst_q) begin
      frac_d  = '0;
      sec_d   = PTC_LONG_RST;
      ns_d    = PTC_LONG_RST;
      phase_d = PTC_PHASE_RST;
    end else if (cmd_load_q) begin
      frac_d  = '0;
      sec_d   = held_sec_q;
      ns_d    = held_ns_q;
      phase_d = held_phase_q;
    end else if (cmd_step_q) begin
      if (step_dir_q) begin
        step_sum = {1'b0, rtc_ns_q} + {1'b0, held_ns_q};
        if (step_sum >= PTC_NS_PER_SEC) begin
          step_sum   = step_sum - PTC_NS_PER_SEC;
          step_carry = 1'b1;
        end
        ns_d  = step_sum[31:0];
        sec_d = rtc_sec_q + held_sec_q + 32'(step_carry);
      end else begin
        if (rtc_ns_q >= held_ns_q) begin
          step_sum = {1'b0, rtc_ns_q} - {1'b0, held_ns_q};
        end else begin
          step_sum   = {1'b0, rtc_ns_q} + PTC_NS_PER_SEC
                       - {1'b0, held_ns_q};
          step_carry = 1'b1;
        end
        ns_d  = step_sum[31:0];
        sec_d = rtc_sec_q - held_sec_q - 32'(step_carry);
      end
    end else if (enable_q && tick) begin
      frac_d = frac_sum[PTC_RATE_W-1:0];
      ns_sum = {1'b0, rtc_ns_q} + 33'(ns_inc);
      if (ns_sum >= PTC_NS_PER_SEC) begin
        ns_sum = ns_sum - PTC_NS_PER_SEC;
        sec_d  = rtc_sec_q + 32'h0000_0001;
      end
      ns_d = ns_sum[31:0];
    end
    // switch timers see the corrected step only when following
    timer_inc_d = no_follow_q ? PTC_TICK_INC : ns_inc;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      frac_q         <= '0;
      rtc_sec_q      <= PTC_LONG_RST;
      rtc_ns_q       <= PTC_LONG_RST;
      rtc_phase_q    <= PTC_PHASE_RST;
      timer_tick_q   <= 1'b0;
      timer_ns_inc_q <= PTC_TICK_INC;
    end else begin
      frac_q         <= frac_d;
      rtc_sec_q      <= sec_d;
      rtc_ns_q       <= ns_d;
      rtc_phase_q    <= phase_d;
      timer_tick_q   <= tick;
      timer_ns_inc_q <= timer_inc_d;
    end
  end

  // ------------------------------------------------------------------
  // register read
  // ------------------------------------------------------------------
  logic [15:0] rdata_d;

  // reserved bits read as zero, unmapped addresses read zero
  always_comb begin
    rdata_d = PTC_WORD_RST;
    if (hit(reg_addr, PTC_OFF_CTRL)) begin
      rdata_d[PTC_CTL_NO_FOLLOW] = no_follow_q;
      rdata_d[PTC_CTL_STEP]      = cmd_step_q;
      rdata_d[PTC_CTL_STEP_DIR]  = step_dir_q;
      rdata_d[PTC_CTL_SNAP]      = cmd_snap_q;
      rdata_d[PTC_CTL_LOAD]      = cmd_load_q;
      rdata_d[PTC_CTL_CONT_ADJ]  = cont_adj_q;
      rdata_d[PTC_CTL_ENABLE]    = enable_q;
      rdata_d[PTC_CTL_RESET]     = cmd_rst_q;
    end else if (hit(reg_addr, PTC_OFF_PHASE)) begin
      rdata_d[PTC_PHASE_W-1:0] = held_phase_q;
    end else if (hit(reg_addr, PTC_OFF_NS_HI)) begin
      rdata_d = held_ns_q[31:16];
    end else if (hit(reg_addr, PTC_OFF_NS_LO)) begin
      rdata_d = held_ns_q[15:0];
    end else if (hit(reg_addr, PTC_OFF_SEC_HI)) begin
      rdata_d = held_sec_q[31:16];
    end else if (hit(reg_addr, PTC_OFF_SEC_LO)) begin
      rdata_d = held_sec_q[15:0];
    end else if (hit(reg_addr, PTC_OFF_RATE_HI)) begin
      rdata_d[PTC_RATE_SIGN]       = rate_sign_select_q;
      rdata_d[PTC_RATE_HI_MSB:0]   = fraction_rate_value_q[PTC_RATE_W-1:16];
    end else if (hit(reg_addr, PTC_OFF_RATE_LO)) begin
      rdata_d = fraction_rate_value_q[15:0];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata_q  <= PTC_WORD_RST;
      reg_rvalid_q <= 1'b0;
    end else begin
      reg_rdata_q  <= reg_rd ? rdata_d : reg_rdata_q;
      reg_rvalid_q <= reg_rd;
    end
  end

endmodule : ptc_time_clock_control

// >>> ptc_chk.sv
// checker for the time clock control block, bound to its top module
`timescale 1ns/1ps
module ptc_chk (
  // clock and reset
  input wire logic        clk,
  input wire logic        arst_n,
  // register port
  input wire logic [15:0] reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata_q,
  input wire logic        reg_rvalid_q,
  // running time and timer reference
  input wire logic [31:0] rtc_sec_q,
  input wire logic [31:0] rtc_ns_q,
  input wire logic [ptc_pkg::PTC_PHASE_W-1:0] rtc_phase_q,
  input wire logic        timer_tick_q,
  input wire logic [6:0]  timer_ns_inc_q
);
  import ptc_pkg::*;
  logic        ctl_wr;
  logic [15:0] ctl_q;
  logic [1:0]  wr_q;
  // ------------------------------------------------------------------
  // shadow of the control word, written state only
  // ------------------------------------------------------------------
  assign ctl_wr = reg_wr && (reg_addr == PTC_OFF_CTRL);
  // write history keeps command edges out of the quiet-time checks
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctl_q <= 16'h0000;
      wr_q  <= 2'b00;
    end else begin
      if (ctl_wr) ctl_q <= reg_wdata;
      wr_q <= {wr_q[0], reg_wr};
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  a_read_answers: assert property (reg_rd |=> reg_rvalid_q)
    else $error("read got no valid pulse");
  a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata_q))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (
    reg_rd && reg_addr[15:4] != 12'h050 |=> reg_rdata_q == 16'h0000)
    else $error("unmapped read not zero");
  a_phase_reserved: assert property (
    reg_rd && reg_addr == PTC_OFF_PHASE |=> reg_rdata_q[15:3] == 13'h0000)
    else $error("phase reserved bits set");
  a_phase_range: assert property (rtc_phase_q <= PTC_PHASE_MAX)
    else $error("phase code invalid");
  a_ns_wraps: assert property (rtc_ns_q < 32'h3B9A_CA00)
    else $error("nanoseconds past one second");
  a_stop_holds: assert property (
    !ctl_q[PTC_CTL_ENABLE] && !reg_wr && wr_q == 2'b00
    |=> $stable(rtc_ns_q) && $stable(rtc_sec_q))
    else $error("time moved while disabled");
  a_tick_step: assert property (
    ctl_q[PTC_CTL_ENABLE] && !ctl_q[PTC_CTL_CONT_ADJ] && !reg_wr
    && wr_q == 2'b00 && rtc_ns_q < 32'h3B9A_C9D8
    |=> rtc_ns_q == $past(rtc_ns_q)
    || rtc_ns_q == $past(rtc_ns_q) + 32'h0000_0028)
    else $error("tick step not 40 ns");
  a_inc_range: assert property (
    timer_ns_inc_q inside {7'h27, 7'h28, 7'h29})
    else $error("timer increment out of range");
  a_nofollow_nominal: assert property (
    ctl_q[PTC_CTL_NO_FOLLOW] && !reg_wr && wr_q == 2'b00
    |-> timer_ns_inc_q == PTC_TICK_INC)
    else $error("timers follow while disabled");
  a_reset_clears: assert property (
    ctl_wr && reg_wdata[PTC_CTL_RESET]
    |-> ##[1:3] (rtc_ns_q == 32'h0000_0000 && rtc_sec_q == 32'h0000_0000))
    else $error("clock reset did not clear time");
  a_tick_period: assert property (
    timer_tick_q |=> !timer_tick_q ##1 timer_tick_q)
    else $error("timer tick not every second clock");
  // main scenarios reached
  c_step: cover property (ctl_wr && reg_wdata[PTC_CTL_STEP]);
  c_fast: cover property (timer_ns_inc_q == 7'h29);
  c_tick: cover property (timer_tick_q && ctl_q[PTC_CTL_ENABLE]);
endmodule : ptc_chk

bind ptc_time_clock_control ptc_chk i_chk (
  .clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
  .reg_rvalid_q(reg_rvalid_q), .rtc_sec_q(rtc_sec_q), .rtc_ns_q(rtc_ns_q),
  .rtc_phase_q(rtc_phase_q), .timer_tick_q(timer_tick_q),
  .timer_ns_inc_q(timer_ns_inc_q));

// >>> ptc_time_clock_control_tb.sv
// register-level testbench for the time clock control block
`timescale 1ns/1ps
module ptc_time_clock_control_tb;
  import ptc_pkg::*;
  logic clk, arst_n, reg_wr, reg_rd, reg_rvalid_q, timer_tick_q;
  logic [15:0] reg_addr, reg_wdata, reg_rdata_q, v;
  logic [31:0] rtc_sec_q, rtc_ns_q, t, s_ns, s_sec, d, n, e;
  logic [2:0]  rtc_phase_q;
  logic [6:0]  timer_ns_inc_q;
  logic        seen_hi, seen_lo;
  int          fails, check_count;

  ptc_time_clock_control i_dut (
    .clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
    .reg_rvalid_q(reg_rvalid_q), .rtc_sec_q(rtc_sec_q),
    .rtc_ns_q(rtc_ns_q), .rtc_phase_q(rtc_phase_q),
    .timer_tick_q(timer_tick_q), .timer_ns_inc_q(timer_ns_inc_q));

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ------------------------------------------------------------------
  // access tasks
  // ------------------------------------------------------------------
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : cyc
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // notes any corrected timer increment over k settled cycles
  task automatic watch(input int k);
    seen_hi = 1'b0;
    seen_lo = 1'b0;
    repeat (k) begin
      cyc(1);
      if (timer_ns_inc_q === 7'h29) seen_hi = 1'b1;
      if (timer_ns_inc_q === 7'h27) seen_lo = 1'b1;
    end
  endtask : watch
  task automatic wr(input logic [15:0] a, input logic [15:0] w);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= w;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : wr
  // read answer is sampled once its valid pulse has settled
  task automatic rdc(input logic [15:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    chk(reg_rvalid_q, 1'b1);
    chk(reg_rdata_q, exp);
  endtask : rdc
  task automatic held(input logic [31:0] ns, input logic [31:0] sec);
    wr(PTC_OFF_NS_HI, ns[31:16]);
    wr(PTC_OFF_NS_LO, ns[15:0]);
    wr(PTC_OFF_SEC_HI, sec[31:16]);
    wr(PTC_OFF_SEC_LO, sec[15:0]);
  endtask : held
  task automatic ld(input logic [2:0] ph, input logic [31:0] ns,
                    input logic [31:0] sec);
    wr(PTC_OFF_PHASE, {13'h0000, ph});
    held(ns, sec);
    wr(PTC_OFF_CTRL, 16'h0008);
    cyc(3);
  endtask : ld
  task automatic stp(input logic [31:0] ns, input logic [31:0] sec,
                     input logic up, input logic [31:0] xn,
                     input logic [31:0] xs);
    held(ns, sec);
    wr(PTC_OFF_CTRL, up ? 16'h0060 : 16'h0040);
    cyc(3);
    chk(rtc_ns_q, xn);
    chk(rtc_sec_q, xs);
  endtask : stp
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out
  // about 500 cycles expected; allow well over ten times that
  initial begin
    #200_000;
    fails++;
    close_out();
  end
  // ------------------------------------------------------------------
  // tests
  // ------------------------------------------------------------------
  initial begin
    reg_addr  = 16'h0000;
    reg_wdata = 16'h0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    arst_n    = 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    cyc(1);
    for (int i = 0; i < 8; i++) begin
      rdc(16'h0500 + 16'(2 * i), 16'h0000);
    end
    chk(timer_ns_inc_q, 7'h28);
    v[0] = timer_tick_q;
    cyc(1);
    chk(timer_tick_q, !v[0]);
    $display("test reset values done");
    cyc(10);
    chk(rtc_ns_q, 32'h0000_0000);
    wr(PTC_OFF_CTRL, 16'h0002);
    cyc(20);
    t = rtc_ns_q;
    chk(t != 0 && t % 40 == 0, 1'b1);
    wr(PTC_OFF_CTRL, 16'h0000);
    cyc(2);
    t = rtc_ns_q;
    cyc(10);
    chk(rtc_ns_q, t);
    $display("test enable done");
    // load just below a second boundary, then let it wrap
    ld(3'h3, 32'h3B9A_C9D8, 32'h0001_0002);
    chk(rtc_ns_q, 32'h3B9A_C9D8);
    chk(rtc_sec_q, 32'h0001_0002);
    chk(rtc_phase_q, 3'h3);
    rdc(PTC_OFF_CTRL, 16'h0000);
    wr(PTC_OFF_CTRL, 16'h0002);
    for (int i = 0; i < 10 && rtc_sec_q !== 32'h0001_0003; i++) cyc(1);
    chk(rtc_sec_q, 32'h0001_0003);
    chk(rtc_ns_q, 32'h0000_0000);
    wr(PTC_OFF_CTRL, 16'h0000);
    $display("test load done");
    // snapshot of a stopped clock, then held while the clock runs
    cyc(2);
    s_ns  = rtc_ns_q;
    s_sec = rtc_sec_q;
    wr(PTC_OFF_NS_HI, 16'hFFFF);
    wr(PTC_OFF_CTRL, 16'h0010);
    cyc(3);
    for (int p = 0; p < 2; p++) begin
      rdc(PTC_OFF_PHASE, 16'h0003);
      rdc(PTC_OFF_NS_HI, s_ns[31:16]);
      rdc(PTC_OFF_NS_LO, s_ns[15:0]);
      rdc(PTC_OFF_SEC_HI, s_sec[31:16]);
      rdc(PTC_OFF_SEC_LO, s_sec[15:0]);
      wr(PTC_OFF_CTRL, 16'h0002);
      cyc(20);
    end
    wr(PTC_OFF_CTRL, 16'h0000);
    $display("test snapshot done");
    ld(3'h4, 32'h0000_03E8, 32'h0000_0005);
    stp(32'h0000_0064, 32'h0000_0001, 1'b1, 32'h0000_044C, 32'h0000_0006);
    rdc(PTC_OFF_CTRL, 16'h0020);
    stp(32'h0000_0064, 32'h0000_0001, 1'b0, 32'h0000_03E8, 32'h0000_0005);
    stp(32'h0000_07D0, 32'h0000_0000, 1'b0, 32'h3B9A_C618, 32'h0000_0004);
    $display("test step done");
    wr(PTC_OFF_CTRL, 16'h0001);
    cyc(3);
    chk({rtc_sec_q, rtc_ns_q} == 64'h0, 1'b1);
    chk(rtc_phase_q, 3'h0);
    rdc(PTC_OFF_CTRL, 16'h0000);
    $display("test clock reset done");
    // half a nanosecond a tick, added then subtracted
    for (int s = 0; s < 2; s++) begin
      wr(PTC_OFF_RATE_HI, (s != 0) ? 16'h2000 : 16'hA000);
      ld(3'h0, 32'h0000_0FA0, 32'h0000_0000);
      wr(PTC_OFF_CTRL, 16'h0006);
      watch(60);
      chk((s != 0) ? seen_lo : seen_hi, 1'b1);
      wr(PTC_OFF_CTRL, 16'h8006);
      cyc(4);
      watch(20);
      chk(seen_hi | seen_lo, 1'b0);
      wr(PTC_OFF_CTRL, 16'h0000);
      cyc(2);
      d = rtc_ns_q - 32'h0000_0FA0;
      n = (s != 0) ? (d + 39) / 40 : d / 40;
      e = (s != 0) ? 40 * n - d : d - 40 * n;
      chk(n > 20 && e + 1 >= n / 2 && e <= n / 2 + 1, 1'b1);
    end
    $display("test rate adjust done");
    wr(PTC_OFF_NS_HI, 16'hA5C3);
    rdc(PTC_OFF_NS_HI, 16'hA5C3);
    wr(PTC_OFF_PHASE, 16'hFFFC);
    rdc(PTC_OFF_PHASE, 16'h0004);
    wr(PTC_OFF_PHASE, 16'h0007);
    rdc(PTC_OFF_PHASE, 16'h0004);
    wr(16'h0520, 16'hFFFF);
    rdc(16'h0520, 16'h0000);
    rdc(16'h0510, 16'h0000);
    $display("test phase and unmapped done");
    close_out();
  end
endmodule : ptc_time_clock_control_tb
